// ==== inc/flash_status_pkg.sv ====
// Constants and types shared by the flash status register bank
package flash_status_pkg;

  // Bit positions within the 24-bit status word
  localparam int unsigned BIT_BUSY       = 0;
  localparam int unsigned BIT_WRLATCH    = 1;
  localparam int unsigned BIT_LEVEL_LO   = 2;
  localparam int unsigned BIT_FOURLANE   = 6;
  localparam int unsigned BIT_REGLOCK    = 7;
  localparam int unsigned BIT_DRIVE_LO   = 8;
  localparam int unsigned BIT_PINFUNC    = 10;
  localparam int unsigned BIT_DIRECTION  = 11;
  localparam int unsigned BIT_STARTUP_AW = 12;
  localparam int unsigned BIT_ADDR_WIDTH = 13;
  localparam int unsigned BIT_LATENCY_LO = 14;
  localparam int unsigned BIT_SEC_ONE    = 16;
  localparam int unsigned BIT_SEC_TWO    = 17;
  localparam int unsigned BIT_PROG_SUSP  = 18;
  localparam int unsigned BIT_ERASE_SUSP = 19;
  localparam int unsigned BIT_SEC_THREE  = 20;
  localparam int unsigned BIT_PROG_ERR   = 21;
  localparam int unsigned BIT_ERASE_ERR  = 22;
  localparam int unsigned BIT_SCHEME     = 23;

  // Values after reset of the nonvolatile image
  localparam logic [1:0] DRIVE_RESET   = 2'h2;
  localparam logic [1:0] LATENCY_RESET = 2'h0;

  // Command codes
  localparam logic [7:0] CMD_WR_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
  localparam logic [7:0] CMD_RD_STAT1   = 8'h05;
  localparam logic [7:0] CMD_RD_STAT2   = 8'h35;
  localparam logic [7:0] CMD_RD_STAT3   = 8'h15;
  localparam logic [7:0] CMD_WR_STAT1   = 8'h01;
  localparam logic [7:0] CMD_WR_STAT2   = 8'h31;
  localparam logic [7:0] CMD_WR_STAT3   = 8'h11;
  localparam logic [7:0] CMD_PROGRAM    = 8'h02;
  localparam logic [7:0] CMD_QPROGRAM   = 8'h32;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLK_ERASE  = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] CMD_CHIP_ERAS2 = 8'h60;
  localparam logic [7:0] CMD_SUSPEND    = 8'h75;
  localparam logic [7:0] CMD_RESUME     = 8'h7a;
  localparam logic [7:0] CMD_CLR_FLAGS  = 8'h30;
  localparam logic [7:0] CMD_ENTER_4B   = 8'hb7;
  localparam logic [7:0] CMD_EXIT_4B    = 8'he9;

  // Dummy clock figures per latency code
  localparam logic [3:0] DUMMY_EIGHT = 4'h8;
  localparam logic [3:0] DUMMY_SIX   = 4'h6;
  localparam logic [3:0] DUMMY_FOUR  = 4'h4;
  localparam logic [3:0] DUMMY_TWO   = 4'h2;
  localparam logic [3:0] DUMMY_NONE  = 4'h0;
  localparam logic [2:0] MODE_DUAL   = 3'h4;
  localparam logic [2:0] MODE_QUAD   = 3'h2;

  // Internal operation durations in core cycles
  localparam int unsigned OP_CYCLES = 64;

  typedef enum logic [1:0] {
    OP_IDLE    = 2'b00,
    OP_PROGRAM = 2'b01,
    OP_ERASE   = 2'b10,
    OP_STATUS  = 2'b11
  } op_kind_t;

endpackage

// ==== hdl/flash_link_shift.sv ====
// Serial link front end: byte assembly and status shift-out on link clock
`timescale 1ns/10ps
module flash_link_shift
  import flash_status_pkg::*;
(
  // Link side
  input  wire logic       i_link_clock,
  input  wire logic       i_select_n,
  input  wire logic       i_data_in,
  output logic            o_data_out,
  output logic            o_data_oe,
  // Byte toward core, toggle per byte
  output logic [7:0]      o_byte,
  output logic            o_byte_toggle,
  output logic            o_first,
  // Status word for read-back, sampled at byte boundary
  input  wire logic [23:0] i_read_word
);

  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] out_q;
  logic       first_q;
  logic [7:0] byte_q;
  logic       toggle_q;
  logic       first_flag_q;
  logic [7:0] link_cmd_q;
  wire  [7:0] byte_d = {shift_q, i_data_in};
  // Chosen here: the core learns the command too late for the first bit
  wire  [7:0] read_sel =
    (link_cmd_q == CMD_RD_STAT2) ? i_read_word[15:8] :
    (link_cmd_q == CMD_RD_STAT3) ? i_read_word[23:16] : i_read_word[7:0];

  // Counter ends with the frame itself: the select pin resets it
  always_ff @(posedge i_link_clock or posedge i_select_n) begin
    if (i_select_n) begin
      bit_cnt_q <= 3'h0;
      first_q   <= 1'b1;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7)
        first_q <= 1'b0;
    end
  end

  always_ff @(posedge i_link_clock) begin
    shift_q <= byte_d[6:0];
    if (bit_cnt_q == 3'h7) begin
      byte_q       <= byte_d;
      first_flag_q <= first_q;
      toggle_q     <= ~toggle_q;
      if (first_q)
        link_cmd_q <= byte_d;
    end
  end

  // Read data shifts out on the falling edge
  always_ff @(negedge i_link_clock or posedge i_select_n) begin
    if (i_select_n) begin
      out_q     <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_data_oe <= ~first_q;
      out_q     <= (bit_cnt_q == 3'h0) ? read_sel : {out_q[6:0], 1'b0};
    end
  end

  assign o_data_out    = out_q[7];
  assign o_byte        = byte_q;
  assign o_byte_toggle = toggle_q;
  assign o_first       = first_flag_q;

endmodule

// ==== hdl/flash_status_register_bank.sv ====
// Status and configuration register bank of a serial NOR flash
`timescale 1ns/10ps
// Notes on behaviour
// - Busy reads 1 during program, erase, status write
// - Latch clear refuses status write, program, erase
// - Direction 0 protects top, 1 bottom
// - Level sizes region; locked under hardware protection
// - Whole erase runs only with nothing protected
// - Lock select 1 with pin low refuses writes
// - Four-lane enable turns control pins into lanes
// - Security locks default 0, set once, stick
// - Suspend sets flag per operation; resume clears both
// - Scheme select chooses level or per-unit locks
// - Reset sets all individual lock bits
// - Drive code selects output strength, default half
// - Pin function pause/reset, dropped in four-lane mode
// - Program error on failure, protected, locked space
// - Erase error on failure; on protected, locked space for sector/block erase only (refused whole erase sets none)
// - Error flags cleared only by clear-flags command or reset
// - Dummy clocks follow latency code; mode clocks follow read kind only
// - Latency code defaults to 00
// - Repeat mode bits allow instruction-less next read
// - Address-width flag shows current addressing
// - Startup width bit picks mode at reset
// - Write-enable sets latch; writes and erases clear it
// - Extended byte used only in three-byte mode
module flash_status_register_bank
  import flash_status_pkg::*;
#(
  parameter int unsigned OP_LEN = OP_CYCLES
)(
  // Core clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // Serial link pins
  input  wire logic        i_link_clock,
  input  wire logic        i_select_n,
  input  wire logic        i_data_in,
  output logic             o_data_out,
  output logic             o_data_oe,
  // Protect and shared control pins
  input  wire logic        i_protect_n,
  input  wire logic        i_pause_reset_n,
  // Array feedback
  input  wire logic        i_fail,
  input  wire logic        i_target_locked,
  input  wire logic        i_otp_access,
  input  wire logic        i_unit_locks_any,
  input  wire logic [7:0]  i_ext_address,
  input  wire logic [1:0]  i_read_kind,
  input  wire logic        i_repeat_bits,
  // Configuration outputs
  output logic [23:0]      o_status,
  output logic [1:0]       o_drive_strength,
  output logic             o_lanes_quad,
  output logic             o_pause_active,
  output logic             o_pin_reset_active,
  output logic             o_protect_bottom,
  output logic             o_protect_all,
  output logic             o_unit_locks_set,
  output logic [7:0]       o_upper_address,
  output logic [3:0]       o_dummy_clocks,
  output logic [2:0]       o_mode_clocks,
  output logic             o_skip_instruction
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] link_byte;
  logic       link_toggle;
  logic       link_first;
  logic [23:0] read_word_q;

  flash_link_shift u_link (
    .i_link_clock  (i_link_clock),
    .i_select_n    (i_select_n),
    .i_data_in     (i_data_in),
    .o_data_out    (o_data_out),
    .o_data_oe     (o_data_oe),
    .o_byte        (link_byte),
    .o_byte_toggle (link_toggle),
    .o_first       (link_first),
    .i_read_word   (read_word_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Crossings: toggle for byte events, two flops for levels
  logic [2:0] tog_sync_q;
  logic [1:0] sel_sync_q;
  logic [1:0] prot_sync_q;
  logic [1:0] pin_sync_q;
  logic [7:0] cmd_q;
  logic       have_cmd_q;
  logic       byte_seen_q;

  always_ff @(posedge i_clock) begin
    tog_sync_q  <= {tog_sync_q[1:0], link_toggle};
    sel_sync_q  <= {sel_sync_q[0], i_select_n};
    prot_sync_q <= {prot_sync_q[0], i_protect_n};
    pin_sync_q  <= {pin_sync_q[0], i_pause_reset_n};
  end

  // Byte data changes on the same link edge as its toggle and then holds for a whole byte time
  wire        byte_evt  = tog_sync_q[2] ^ tog_sync_q[1];
  wire        frame_end = sel_sync_q[1] & ~byte_seen_q & have_cmd_q;
  wire        prot_high = prot_sync_q[1];

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      cmd_q       <= 8'h00;
      have_cmd_q  <= 1'b0;
      byte_seen_q <= 1'b0;
    end else if (byte_evt && link_first) begin
      cmd_q       <= link_byte;
      have_cmd_q  <= 1'b1;
      byte_seen_q <= 1'b0;
    end else if (byte_evt) begin
      byte_seen_q <= 1'b1;
    end else if (sel_sync_q[1]) begin
      have_cmd_q  <= 1'b0;
      byte_seen_q <= 1'b0;
    end
  end

  // Data byte of a status write, taken as soon as it arrives
  wire data_evt = byte_evt & ~link_first & have_cmd_q & ~byte_seen_q;

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic       busy_flag_q, write_latch_flag_q;
  logic [3:0] protect_level_field_q;
  logic       four_lane_enable_q, register_lock_select_q;
  logic [1:0] drive_strength_code_q;
  logic       pin_function_q, protect_direction_bit_q;
  logic       startup_address_width_q, address_width_flag_q;
  logic [1:0] latency_code_q;
  logic [2:0] security_lock_q;
  logic       program_suspended_flag_q, erase_suspended_flag_q;
  logic       program_error_flag_q, erase_error_flag_q;
  logic       protect_scheme_select_q;
  op_kind_t   op_q;
  logic [15:0] op_cnt_q;

  wire is_cmd    = frame_end;
  wire cmd_prog  = is_cmd & (cmd_q == CMD_PROGRAM | cmd_q == CMD_QPROGRAM);
  wire cmd_erase = is_cmd & (cmd_q == CMD_SECT_ERASE |
                             cmd_q == CMD_BLK_ERASE);
  wire cmd_chip  = is_cmd & (cmd_q == CMD_CHIP_ERASE |
                             cmd_q == CMD_CHIP_ERAS2);
  wire cmd_wstat = data_evt & (cmd_q == CMD_WR_STAT1 |
                   cmd_q == CMD_WR_STAT2 | cmd_q == CMD_WR_STAT3);

  // Protection decode
  wire level_all   = (protect_level_field_q[3:2] == 2'h3) |
                     (protect_level_field_q == 4'hb);
  wire any_protect = protect_scheme_select_q ? i_unit_locks_any :
                     (protect_level_field_q != 4'h0);
  wire hw_locked   = register_lock_select_q & ~prot_high;
  wire idle        = (op_q == OP_IDLE);
  wire go_ok       = write_latch_flag_q & idle;
  wire prot_hit    = i_target_locked | i_otp_access;
  wire start_prog  = cmd_prog & go_ok & ~prot_hit;
  wire start_erase = (cmd_erase & go_ok & ~prot_hit) |
                     (cmd_chip & go_ok & ~any_protect);
  wire start_wstat = cmd_wstat & go_ok & ~hw_locked;
  wire op_done     = ~idle & (op_cnt_q == 16'(OP_LEN - 1));

  ////////////////////////////////////////////////////////////////////////
  // Operation sequencer; busy follows it
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      op_q     <= OP_IDLE;
      op_cnt_q <= 16'h0000;
    end else if (start_prog) begin
      op_q     <= OP_PROGRAM;
      op_cnt_q <= 16'h0000;
    end else if (start_erase) begin
      op_q     <= OP_ERASE;
      op_cnt_q <= 16'h0000;
    end else if (start_wstat) begin
      op_q     <= OP_STATUS;
      op_cnt_q <= 16'h0000;
    end else if (op_done) begin
      op_q     <= OP_IDLE;
    end else if (!idle && !program_suspended_flag_q &&
                 !erase_suspended_flag_q) begin
      op_cnt_q <= op_cnt_q + 16'h0001;
    end
  end

  wire suspend = is_cmd & (cmd_q == CMD_SUSPEND);
  wire resume  = is_cmd & (cmd_q == CMD_RESUME);
  wire clr_err = is_cmd & (cmd_q == CMD_CLR_FLAGS);

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      busy_flag_q              <= 1'b0;
      write_latch_flag_q       <= 1'b0;
      program_suspended_flag_q <= 1'b0;
      erase_suspended_flag_q   <= 1'b0;
      program_error_flag_q     <= 1'b0;
      erase_error_flag_q       <= 1'b0;
    end else begin
      busy_flag_q <= (start_prog | start_erase | start_wstat) |
                     (~idle & ~op_done);
      if (is_cmd && cmd_q == CMD_WR_ENABLE)
        write_latch_flag_q <= 1'b1;
      else if ((is_cmd && cmd_q == CMD_WR_DISABLE) || start_wstat ||
               start_prog || start_erase)
        write_latch_flag_q <= 1'b0;
      if (suspend && op_q == OP_PROGRAM)
        program_suspended_flag_q <= 1'b1;
      else if (resume)
        program_suspended_flag_q <= 1'b0;
      if (suspend && op_q == OP_ERASE)
        erase_suspended_flag_q <= 1'b1;
      else if (resume)
        erase_suspended_flag_q <= 1'b0;
      // Set wins over clear on the same edge
      if ((cmd_prog && write_latch_flag_q && prot_hit) ||
          (op_done && op_q == OP_PROGRAM && i_fail))
        program_error_flag_q <= 1'b1;
      else if (clr_err)
        program_error_flag_q <= 1'b0;
      if ((cmd_erase && write_latch_flag_q && prot_hit) ||
          (op_done && op_q == OP_ERASE && i_fail))
        erase_error_flag_q <= 1'b1;
      else if (clr_err)
        erase_error_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable image; applied when the write completes would be nicer,
  // but value is committed at acceptance so readers see it at once
  wire wr1 = start_wstat & (cmd_q == CMD_WR_STAT1);
  wire wr2 = start_wstat & (cmd_q == CMD_WR_STAT2);
  wire wr3 = start_wstat & (cmd_q == CMD_WR_STAT3);

  // Nonvolatile bits take defaults only at the first reset after power-up
  logic powered_q = 1'b0;
  always_ff @(posedge i_clock) begin
    powered_q <= powered_q | ~i_reset_n;
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      if (!powered_q) begin
      protect_level_field_q   <= 4'h0;
      four_lane_enable_q      <= 1'b0;
      register_lock_select_q  <= 1'b0;
      drive_strength_code_q   <= DRIVE_RESET;
      pin_function_q          <= 1'b0;
      protect_direction_bit_q <= 1'b0;
      startup_address_width_q <= 1'b0;
      latency_code_q          <= LATENCY_RESET;
      security_lock_q         <= 3'h0;
      protect_scheme_select_q <= 1'b0;
      end
    end else begin
      if (wr1) begin
        protect_level_field_q  <= link_byte[5:2];
        four_lane_enable_q     <= link_byte[BIT_FOURLANE];
        register_lock_select_q <= link_byte[BIT_REGLOCK];
      end
      if (wr2) begin
        drive_strength_code_q   <= link_byte[1:0];
        pin_function_q          <= link_byte[2];
        protect_direction_bit_q <= link_byte[3];
        startup_address_width_q <= link_byte[4];
        latency_code_q          <= link_byte[7:6];
      end
      if (wr3) begin
        security_lock_q <= security_lock_q |
                           {link_byte[4], link_byte[1:0]};
        protect_scheme_select_q <= link_byte[7];
      end
    end
  end

  // Mode follows startup bit at reset, then enter/exit commands
  logic aw_init_q;
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      aw_init_q            <= 1'b1;
      address_width_flag_q <= 1'b0;
    end else if (aw_init_q) begin
      aw_init_q            <= 1'b0;
      address_width_flag_q <= startup_address_width_q;
    end else if (is_cmd && cmd_q == CMD_ENTER_4B) begin
      address_width_flag_q <= 1'b1;
    end else if (is_cmd && cmd_q == CMD_EXIT_4B) begin
      address_width_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  wire [23:0] status_w = {
    protect_scheme_select_q, erase_error_flag_q, program_error_flag_q,
    security_lock_q[2], erase_suspended_flag_q, program_suspended_flag_q,
    security_lock_q[1:0], latency_code_q, address_width_flag_q,
    startup_address_width_q, protect_direction_bit_q, pin_function_q,
    drive_strength_code_q, register_lock_select_q, four_lane_enable_q,
    protect_level_field_q, write_latch_flag_q, busy_flag_q};

  // Dummy clocks: read kind 0 fast, 1 dual-out/quad-out, 2 dual-IO, 3 quad-IO
  wire       lc_fast = (latency_code_q == 2'h3);
  wire       lc_zero = (latency_code_q == 2'h0);
  wire [3:0] dummy_w =
    (i_read_kind == 2'h0) ? (lc_fast ? DUMMY_NONE : DUMMY_EIGHT) :
    (i_read_kind == 2'h1) ? (lc_fast ? DUMMY_SIX  : DUMMY_EIGHT) :
    (i_read_kind == 2'h2) ? ((lc_fast | lc_zero) ? DUMMY_NONE : DUMMY_TWO) :
                            ((lc_fast | lc_zero) ? DUMMY_FOUR : DUMMY_SIX);
  wire [2:0] mode_w = (i_read_kind == 2'h2) ? MODE_DUAL :
                      (i_read_kind == 2'h3) ? MODE_QUAD : 3'h0;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      read_word_q        <= 24'h000000;
      o_status           <= 24'h000000;
      o_drive_strength   <= DRIVE_RESET;
      o_lanes_quad       <= 1'b0;
      o_pause_active     <= 1'b0;
      o_pin_reset_active <= 1'b0;
      o_protect_bottom   <= 1'b0;
      o_protect_all      <= 1'b0;
      o_unit_locks_set   <= 1'b0;
      o_upper_address    <= 8'h00;
      o_dummy_clocks     <= DUMMY_NONE;
      o_mode_clocks      <= 3'h0;
      o_skip_instruction <= 1'b0;
    end else begin
      read_word_q        <= status_w;
      o_status           <= status_w;
      o_drive_strength   <= drive_strength_code_q;
      o_lanes_quad       <= four_lane_enable_q;
      o_pause_active     <= ~four_lane_enable_q & ~pin_function_q &
                            ~pin_sync_q[1];
      o_pin_reset_active <= ~four_lane_enable_q & pin_function_q &
                            ~pin_sync_q[1];
      o_protect_bottom   <= protect_direction_bit_q &
                            ~protect_scheme_select_q;
      o_protect_all      <= level_all & ~protect_scheme_select_q;
      o_unit_locks_set   <= 1'b1;
      o_upper_address    <= address_width_flag_q ? 8'h00 :
                            i_ext_address;
      o_dummy_clocks     <= dummy_w;
      o_mode_clocks      <= mode_w;
      o_skip_instruction <= i_repeat_bits & i_read_kind[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_refused_write;
    cmd_wstat && (!write_latch_flag_q || hw_locked);
  endsequence

  a_refused_write_keeps: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) s_refused_write |=> !busy_flag_q || $past(!idle))
    else $error("refused status write started an operation");

  a_busy_on_start: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) (start_prog || start_erase) |=> busy_flag_q)
    else $error("busy not set at operation start");

  a_latch_clear_go: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) start_prog |=> !write_latch_flag_q)
    else $error("write latch not cleared by program");

  a_chip_erase_guard: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) (cmd_chip && any_protect) |=> op_q != OP_ERASE
      || $past(op_q) == OP_ERASE)
    else $error("whole erase ran with protection");

  a_lock_sticky: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) security_lock_q[0] |=> security_lock_q[0])
    else $error("security lock returned to zero");

  a_error_hold: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) (program_error_flag_q && !clr_err)
      |=> program_error_flag_q)
    else $error("program error dropped without clear");

  a_resume_clears: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) (resume && !suspend)
      |=> !erase_suspended_flag_q && !program_suspended_flag_q)
    else $error("resume left a suspend flag");

  a_hw_level_lock: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) hw_locked && !start_wstat
      |=> $stable(protect_level_field_q))
    else $error("level changed under hardware lock");

endmodule

// ==== sim/flash_host_model.sv ====
// Host serial controller model that drives command frames
`timescale 1ns/10ps
module flash_host_model (
  // Link pins
  output logic      o_link_clock,
  output logic      o_select_n,
  output logic      o_data_out,
  input  wire logic i_data_in
);
  initial begin
    o_link_clock = 1'b0;
    o_select_n   = 1'b1;
    o_data_out   = 1'b1;
  end
  // Clock stands low between frames; bytes go out MSB first
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1,
                       input int nb, output logic [7:0] rd);
    rd = 8'h00;
    o_select_n = 1'b0;
    #50;
    for (int i = 0; i < nb * 8; i++) begin
      o_data_out = (i < 8) ? b0[7 - i] : b1[15 - i];
      #62.5 o_link_clock = 1'b1;
      if (i >= 8) rd = {rd[6:0], i_data_in};
      #62.5 o_link_clock = 1'b0;
    end
    #50 o_select_n = 1'b1;
    // Released line flips so stale data never reads as valid
    o_data_out = ~o_data_out;
    #300;
  endtask
endmodule

// ==== sim/test_flash_status_register_bank.sv ====
// Self-checking bench for the flash status register bank
`timescale 1ns/10ps
module test_flash_status_register_bank;
  import flash_status_pkg::*;
  logic       i_clock = 1'b0;
  logic       i_reset_n = 1'b0;
  logic       i_protect_n = 1'b1;
  logic       i_pause_n = 1'b1;
  logic       i_fail = 1'b0;
  logic [1:0] i_read_kind = 2'h0;
  logic       i_repeat = 1'b0;
  wire        o_skip;
  wire        lclk, sel_n, mosi, miso;
  wire [23:0] o_status;
  wire [1:0]  o_drive;
  wire [3:0]  o_dummy;
  wire [2:0]  o_mode;
  wire [7:0]  o_upper;
  wire        o_quad, o_pause, o_bottom, o_all, o_locks;
  int         errors = 0;
  int         checks_done = 0;
  int         cyc = 0;
  int         bsy = 0;
  int         dt [4][4] = '{'{8,8,0,4}, '{8,8,2,6}, '{8,8,2,6}, '{0,6,0,4}};
  int         mt [4] = '{0,0,4,2};
  flash_host_model host (.o_link_clock(lclk), .o_select_n(sel_n),
    .o_data_out(mosi), .i_data_in(miso));
  // Short operations keep each busy wait near a hundred cycles
  flash_status_register_bank #(.OP_LEN(100)) DUT (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_link_clock(lclk),
    .i_select_n(sel_n), .i_data_in(mosi), .o_data_out(miso),
    .o_data_oe(), .i_protect_n(i_protect_n), .i_pause_reset_n(i_pause_n),
    .i_fail(i_fail), .i_target_locked(1'b0), .i_otp_access(1'b0),
    .i_unit_locks_any(1'b0), .i_ext_address(8'h5a),
    .i_read_kind(i_read_kind), .i_repeat_bits(i_repeat), .o_status(o_status),
    .o_drive_strength(o_drive), .o_lanes_quad(o_quad),
    .o_pause_active(o_pause), .o_pin_reset_active(),
    .o_protect_bottom(o_bottom), .o_protect_all(o_all),
    .o_unit_locks_set(o_locks), .o_upper_address(o_upper),
    .o_dummy_clocks(o_dummy), .o_mode_clocks(o_mode),
    .o_skip_instruction(o_skip));
  always #20 i_clock = ~i_clock;
  always @(posedge i_clock) bsy <= bsy + (o_status[BIT_BUSY] === 1'b1);
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // When w is set, waits out busy (up to 400 cycles) so the next frame is not refused for it
  task automatic send(input logic [7:0] c, input logic [7:0] d,
                      input int nb, input bit w);
    logic [7:0] r;
    host.frame(c, d, nb, r);
    for (int k = 0; w && k < 400 && o_status[BIT_BUSY] !== 1'b0; k++)
      @(posedge i_clock);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    send(CMD_WR_ENABLE, 8'h00, 1, 1);
    send(c, d, 2, 1);
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] r);
    host.frame(c, 8'h00, 2, r);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] r;
    int b0;
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    rd(CMD_RD_STAT1, r); chk(r, 8'h00);
    rd(CMD_RD_STAT2, r); chk(r, 8'h02);
    rd(CMD_RD_STAT3, r); chk(r, 8'h00);
    chk(o_drive, 2'h2);
    chk(o_locks, 1'b1);
    chk(o_upper, 8'h5a);
    $display("reset test done");
    send(CMD_WR_STAT1, 8'h3c, 2, 1);
    rd(CMD_RD_STAT1, r); chk(r, 8'h00);
    send(CMD_WR_ENABLE, 8'h00, 1, 1);
    rd(CMD_RD_STAT1, r); chk(r, 8'h02);
    b0 = bsy;
    wr(CMD_WR_STAT1, 8'h2c);
    chk(bsy > b0, 1'b1);
    rd(CMD_RD_STAT1, r); chk(r, 8'h2c);
    chk(o_all, 1'b1);
    wr(CMD_WR_STAT1, 8'h24);
    chk(o_all, 1'b0);
    b0 = bsy;
    send(CMD_WR_ENABLE, 8'h00, 1, 1);
    send(CMD_CHIP_ERASE, 8'h00, 1, 1);
    chk(bsy == b0, 1'b1);
    $display("protect test done");
    wr(CMD_WR_STAT1, 8'h80);
    @(posedge i_clock) i_protect_n <= 1'b0;
    wr(CMD_WR_STAT1, 8'h04);
    rd(CMD_RD_STAT1, r); chk(r & 8'hfd, 8'h80);
    @(posedge i_clock) i_protect_n <= 1'b1;
    wr(CMD_WR_STAT1, 8'h00);
    rd(CMD_RD_STAT1, r); chk(r, 8'h00);
    @(posedge i_clock) i_pause_n <= 1'b0;
    wr(CMD_WR_STAT1, 8'h40);
    chk(o_quad, 1'b1);
    chk(o_pause, 1'b0);
    wr(CMD_WR_STAT1, 8'h00);
    chk(o_pause, 1'b1);
    @(posedge i_clock) i_pause_n <= 1'b1;
    $display("lock test done");
    send(CMD_WR_ENABLE, 8'h00, 1, 1);
    send(CMD_CHIP_ERASE, 8'h00, 1, 0);
    send(CMD_SUSPEND, 8'h00, 1, 0);
    rd(CMD_RD_STAT3, r); chk(r, 8'h08);
    @(posedge i_clock) i_fail <= 1'b1;
    send(CMD_RESUME, 8'h00, 1, 1);
    rd(CMD_RD_STAT3, r); chk(r, 8'h40);
    @(posedge i_clock) i_fail <= 1'b0;
    send(CMD_CLR_FLAGS, 8'h00, 1, 1);
    rd(CMD_RD_STAT3, r); chk(r, 8'h00);
    $display("erase test done");
    for (int k = 0; k < 4; k++) begin
      wr(CMD_WR_STAT2, 8'h08 | k[7:0]);
      chk(o_drive, k[1:0]);
    end
    chk(o_bottom, 1'b1);
    for (int l = 0; l < 4; l++) begin
      wr(CMD_WR_STAT2, {l[1:0], 6'h0a});
      for (int k = 0; k < 4; k++) begin
        @(posedge i_clock) i_read_kind <= k[1:0];
        repeat (4) @(posedge i_clock);
        chk(o_dummy, dt[l][k]);
        chk(o_mode, mt[k]);
      end
    end
    chk(o_skip, 1'b0);
    @(posedge i_clock) i_repeat <= 1'b1;
    repeat (4) @(posedge i_clock);
    chk(o_skip, 1'b1);
    @(posedge i_clock) i_repeat <= 1'b0;
    $display("config test done");
    wr(CMD_WR_STAT3, 8'h13);
    rd(CMD_RD_STAT3, r); chk(r, 8'h13);
    wr(CMD_WR_STAT3, 8'h00);
    rd(CMD_RD_STAT3, r); chk(r, 8'h13);
    wr(CMD_WR_STAT2, 8'h12);
    @(posedge i_clock) i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    chk(o_status[BIT_ADDR_WIDTH], 1'b1);
    chk(o_upper, 8'h00);
    $display("address test done");
    end_sim();
  end
endmodule
